// ### compare_match_pkg.sv
package compare_match_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  OFF_CONTROL     = 4'h0;
	localparam logic [3:0]  OFF_VALUE       = 4'h4;
	localparam logic [3:0]  OFF_STATUS      = 4'h8;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTL_MODE_LSB    = 0;
	localparam int          CTL_TBASE_BIT   = 4;
	localparam int          CTL_DIR_BIT     = 5;
	localparam int          STS_FLAG_BIT    = 0;
	localparam int          STS_LATCH_BIT   = 1;
	localparam int          COUNT_W         = 16;
	localparam logic [3:0]  MODE_RST        = 4'h0;
	localparam logic        DIR_RST         = 1'b1;
	localparam logic [15:0] VALUE_RST       = 16'h0000;

	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;

	// ----------------------------------------------------------------
	// compare modes
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		MODE_OFF       = 4'b0000,
		MODE_TOGGLE    = 4'b0010,
		MODE_SET_HIGH  = 4'b1000,
		MODE_SET_LOW   = 4'b1001,
		MODE_SOFT_INT  = 4'b1010,
		MODE_SPECIAL   = 4'b1011
	} compare_mode_e;

	// timer reset and converter start pulses
	typedef struct packed {
		logic timer_a_reset;
		logic timer_b_reset;
		logic conv_start;
	} trigger_s;

	function automatic logic is_compare_mode(input logic [3:0] m);
		return (m == MODE_TOGGLE) || (m[3:2] == 2'b10);
	endfunction

	function automatic logic drives_pin(input logic [3:0] m);
		return (m == MODE_TOGGLE) || (m == MODE_SET_HIGH) || (m == MODE_SET_LOW);
	endfunction

	function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] nw, input logic en);
		return en ? nw : old;
	endfunction

endpackage

// ### match_detect.sv
`timescale 1ns/1ps
module match_detect
	import compare_match_pkg::*;
#(
	parameter int W = COUNT_W
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         enable,
	input  wire logic [W-1:0] count,
	input  wire logic [W-1:0] value,
	output logic              hit
);

	typedef struct packed {
		logic was_equal;
		logic hit;
	} det_s;

	det_s st;
	det_s next_st;
	logic equal;

	// ----------------------------------------------------------------
	// one pulse per occurrence of equality
	// ----------------------------------------------------------------
	always_comb begin
		equal             = enable && (count == value);
		next_st.was_equal = equal;
		next_st.hit       = equal && !st.was_equal;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign hit = st.hit;

endmodule

// ### compare_match_unit.sv
`timescale 1ns/1ps
// How it works
// - compare value against selected timer count
// - match drives pin high, low, toggle
// - match flag set with the pin action
// - clearing control forces compare latch low
// - mode 1010 sets flag only
// - mode 1011 raises special event trigger
// - trigger resets the selected time base
// - trigger starts conversion only if enabled
module compare_match_unit
	import compare_match_pkg::*;
(
	input  wire logic               MCLK,
	input  wire logic               RST_N,
	input  wire logic [ADDR_W-1:0]  S_AWADDR,
	input  wire logic               S_AWVALID,
	output logic                    S_AWREADY,
	input  wire logic [31:0]        S_WDATA,
	input  wire logic [3:0]         S_WSTRB,
	input  wire logic               S_WVALID,
	output logic                    S_WREADY,
	output logic [1:0]              S_BRESP,
	output logic                    S_BVALID,
	input  wire logic               S_BREADY,
	input  wire logic [ADDR_W-1:0]  S_ARADDR,
	input  wire logic               S_ARVALID,
	output logic                    S_ARREADY,
	output logic [31:0]             S_RDATA,
	output logic [1:0]              S_RRESP,
	output logic                    S_RVALID,
	input  wire logic               S_RREADY,
	input  wire logic [COUNT_W-1:0] TIMER_A_COUNT,
	input  wire logic [COUNT_W-1:0] TIMER_B_COUNT,
	input  wire logic               PORT_LATCH,
	input  wire logic               CONV_ENABLED,
	output logic                    COMPARE_PIN_O,
	output logic                    COMPARE_PIN_OE,
	output trigger_s                TRIGGER
);

	typedef struct packed {
		logic                aw_held;
		logic [ADDR_W-1:0]   awaddr;
		logic                w_held;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [3:0]          mode;
		logic                time_base_b;
		logic                pin_dir;
		logic [COUNT_W-1:0]  value;
		logic                flag;
		logic                cmp_latch;
		logic                pin_o;
		logic                pin_oe;
		trigger_s            trig;
	} state_s;

	state_s             st;
	state_s             next_st;
	logic               hit;
	logic [COUNT_W-1:0] sel_count;
	logic               do_write;
	logic [31:0]        ctl_word;
	logic [31:0]        sts_word;

	// ----------------------------------------------------------------
	// time base selection and match detection
	// ----------------------------------------------------------------
	assign sel_count = st.time_base_b ? TIMER_B_COUNT : TIMER_A_COUNT;

	match_detect #(
		.W      (COUNT_W)
	) u_match (
		.clk    (MCLK),
		.rst_n  (RST_N),
		.enable (is_compare_mode(st.mode)),
		.count  (sel_count),
		.value  (st.value),
		.hit    (hit)
	);

	assign ctl_word = {26'h0000000, st.pin_dir, st.time_base_b, st.mode};
	assign sts_word = {30'h00000000, st.cmp_latch, st.flag};
	assign do_write = st.aw_held && st.w_held && !st.bvalid;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_st = st;

		// write address and data are taken in either order
		if (S_AWVALID && st.awready) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr  = S_AWADDR;
		end
		if (S_WVALID && st.wready) begin
			next_st.w_held = 1'b1;
			next_st.wdata  = S_WDATA;
			next_st.wstrb  = S_WSTRB;
		end
		if (st.bvalid && S_BREADY) begin
			next_st.bvalid = 1'b0;
		end

		// compare action on a match
		next_st.trig = '0;
		if (hit) begin
			next_st.flag = 1'b1;
			unique case (st.mode)
				MODE_SET_HIGH: next_st.cmp_latch = 1'b1;
				MODE_SET_LOW:  next_st.cmp_latch = 1'b0;
				MODE_TOGGLE:   next_st.cmp_latch = !st.cmp_latch;
				MODE_SPECIAL: begin
					next_st.trig.timer_a_reset = !st.time_base_b;
					next_st.trig.timer_b_reset = st.time_base_b;
					next_st.trig.conv_start    = CONV_ENABLED;
				end
				default: ;
			endcase
		end

		// register write
		if (do_write) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = RESP_OKAY;
			unique case (st.awaddr)
				OFF_CONTROL: begin
					if (st.wstrb[0]) begin
						next_st.mode        = st.wdata[CTL_MODE_LSB +: 4];
						next_st.time_base_b = st.wdata[CTL_TBASE_BIT];
						next_st.pin_dir     = st.wdata[CTL_DIR_BIT];
						if (st.wdata[7:0] == 8'h00) begin
							next_st.cmp_latch = 1'b0;
						end
					end
				end
				OFF_VALUE: begin
					next_st.value[7:0]  = merge_byte(st.value[7:0], st.wdata[7:0], st.wstrb[0]);
					next_st.value[15:8] = merge_byte(st.value[15:8], st.wdata[15:8], st.wstrb[1]);
				end
				OFF_STATUS: begin
					// write one clears; a match in the same cycle wins
					if (st.wstrb[0] && st.wdata[STS_FLAG_BIT] && !hit) begin
						next_st.flag = 1'b0;
					end
				end
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end

		next_st.awready = !next_st.aw_held && !next_st.bvalid;
		next_st.wready  = !next_st.w_held && !next_st.bvalid;

		// register read
		if (st.rvalid && S_RREADY) begin
			next_st.rvalid = 1'b0;
		end
		if (S_ARVALID && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = RESP_OKAY;
			unique case (S_ARADDR)
				OFF_CONTROL: next_st.rdata = ctl_word;
				OFF_VALUE:   next_st.rdata = {16'h0000, st.value};
				OFF_STATUS:  next_st.rdata = sts_word;
				default: begin
					next_st.rdata = 32'h00000000;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		next_st.arready = !next_st.rvalid;

		// pin: compare latch in driving modes, else the port latch
		next_st.pin_o  = drives_pin(next_st.mode) ? next_st.cmp_latch : PORT_LATCH;
		next_st.pin_oe = !next_st.pin_dir;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st         <= '0;
			st.mode    <= MODE_RST;
			st.pin_dir <= DIR_RST;
			st.value   <= VALUE_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign S_AWREADY      = st.awready;
	assign S_WREADY       = st.wready;
	assign S_BVALID       = st.bvalid;
	assign S_BRESP        = st.bresp;
	assign S_ARREADY      = st.arready;
	assign S_RVALID       = st.rvalid;
	assign S_RDATA        = st.rdata;
	assign S_RRESP        = st.rresp;
	assign COMPARE_PIN_O  = st.pin_o;
	assign COMPARE_PIN_OE = st.pin_oe;
	assign TRIGGER        = st.trig;

endmodule

// ### cmu_asserts.sv
`timescale 1ns/1ps
module cmu_asserts
	import compare_match_pkg::*;
(
	input wire logic        MCLK, RST_N, S_AWVALID, S_AWREADY, S_WVALID, S_WREADY,
	input wire logic        S_BVALID, S_ARREADY, S_RVALID, PORT_LATCH, COMPARE_PIN_O,
	input wire logic [3:0]  S_AWADDR,
	input wire logic [31:0] S_WDATA,
	input wire logic [15:0] TIMER_A_COUNT, TIMER_B_COUNT,
	input wire trigger_s    TRIGGER
);
	logic [5:0]  ctl;
	logic [15:0] val;
	logic        eq;
	logic        pend;
	logic [3:0]  pa;
	logic [31:0] pd;
	// shadow of mode, time base and value; a write lands one edge after it is taken
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ctl  <= {DIR_RST, 1'b0, MODE_RST};
			val  <= VALUE_RST;
			pend <= 1'b0;
			pa   <= 4'h0;
			pd   <= 32'h00000000;
		end else begin
			pend <= S_AWVALID && S_AWREADY && S_WVALID && S_WREADY;
			pa   <= S_AWADDR;
			pd   <= S_WDATA;
			if (pend && (pa == OFF_CONTROL)) ctl <= pd[5:0];
			if (pend && (pa == OFF_VALUE)) val <= pd[15:0];
		end
	end
	assign eq = (ctl[3:0] inside {4'h2, 4'h8, 4'h9, 4'ha, 4'hb}) && ((ctl[4] ? TIMER_B_COUNT : TIMER_A_COUNT) == val);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence s_hit(logic [3:0] m);
		eq && !$past(eq) && ctl[3:0] == m;
	endsequence
	property p_high; s_hit(4'h8) |-> ##2 COMPARE_PIN_O; endproperty
	a_high: assert property (p_high) else $error("pin not high");
	property p_low; s_hit(4'h9) |-> ##2 !COMPARE_PIN_O; endproperty
	a_low: assert property (p_low) else $error("pin not low");
	property p_tog; s_hit(4'h2) |-> ##2 COMPARE_PIN_O != $past(COMPARE_PIN_O); endproperty
	a_tog: assert property (p_tog) else $error("pin not toggled");
	property p_soft; s_hit(4'ha) |-> ##2 (TRIGGER == 3'b000) && (COMPARE_PIN_O == PORT_LATCH); endproperty
	a_soft: assert property (p_soft) else $error("flag-only mode acted");
	property p_spec; s_hit(4'hb) |-> ##2 (ctl[4] ? TRIGGER.timer_b_reset : TRIGGER.timer_a_reset); endproperty
	a_spec: assert property (p_spec) else $error("no trigger");
	property p_cause; |TRIGGER |-> $past(eq, 2) && !$past(eq, 3); endproperty
	a_cause: assert property (p_cause) else $error("trigger without match");
	property p_one; |TRIGGER |-> TRIGGER.timer_a_reset ^ TRIGGER.timer_b_reset; endproperty
	a_one: assert property (p_one) else $error("bad trigger bits");
	property p_pulse; |TRIGGER |=> !(|TRIGGER); endproperty
	a_pulse: assert property (p_pulse) else $error("trigger too long");
	property p_bref; S_BVALID |-> !S_AWREADY; endproperty
	a_bref: assert property (p_bref) else $error("aw ready with response");
	property p_rref; S_RVALID |-> !S_ARREADY; endproperty
	a_rref: assert property (p_rref) else $error("ar ready with data");
endmodule
bind compare_match_unit cmu_asserts chk (.MCLK, .RST_N, .S_AWVALID, .S_AWREADY, .S_WVALID, .S_WREADY, .S_BVALID,
	.S_ARREADY, .S_RVALID, .PORT_LATCH, .COMPARE_PIN_O, .S_AWADDR, .S_WDATA, .TIMER_A_COUNT, .TIMER_B_COUNT, .TRIGGER);

// ### timer_conv_model.sv
`timescale 1ns/1ps
module timer_conv_model
	import compare_match_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  run,
	input  wire logic  clr,
	input  wire trigger_s trig,
	output logic [15:0] cnt_a,
	output logic [15:0] cnt_b,
	output logic [7:0]  conv_cnt
);
	// both timers step on the core clock only, never asynchronously
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_a <= 16'h0000;
			cnt_b <= 16'h0000;
			conv_cnt <= 8'h00;
		end else begin
			cnt_a <= (clr || trig.timer_a_reset) ? 16'h0000 : cnt_a + 16'(run);
			cnt_b <= (clr || trig.timer_b_reset) ? 16'h0000 : cnt_b + 16'(run);
			conv_cnt <= conv_cnt + 8'(trig.conv_start);
		end
	end
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb
	import compare_match_pkg::*;
;
	logic MCLK, RST_N, S_AWVALID, S_WVALID, S_BREADY, S_ARVALID, S_RREADY, PORT_LATCH, CONV_ENABLED, run, clr;
	logic S_AWREADY, S_WREADY, S_BVALID, S_ARREADY, S_RVALID, COMPARE_PIN_O, COMPARE_PIN_OE;
	logic [3:0]  S_AWADDR, S_ARADDR, S_WSTRB;
	logic [31:0] S_WDATA, S_RDATA;
	logic [1:0]  S_BRESP, S_RRESP;
	logic [15:0] TIMER_A_COUNT, TIMER_B_COUNT;
	logic [7:0]  conv_cnt, c0;
	trigger_s    TRIGGER;
	int          error_cnt = 0;
	int          total_checks = 0;
	compare_match_unit uut (.MCLK, .RST_N, .S_AWADDR, .S_AWVALID, .S_AWREADY, .S_WDATA, .S_WSTRB, .S_WVALID,
		.S_WREADY, .S_BRESP, .S_BVALID, .S_BREADY, .S_ARADDR, .S_ARVALID, .S_ARREADY, .S_RDATA, .S_RRESP,
		.S_RVALID, .S_RREADY, .TIMER_A_COUNT, .TIMER_B_COUNT, .PORT_LATCH, .CONV_ENABLED, .COMPARE_PIN_O,
		.COMPARE_PIN_OE, .TRIGGER);
	timer_conv_model tm (.clk(MCLK), .rst_n(RST_N), .run, .clr, .trig(TRIGGER), .cnt_a(TIMER_A_COUNT),
		.cnt_b(TIMER_B_COUNT), .conv_cnt);
	initial begin
		MCLK = 1'b0;
		forever #5 MCLK = ~MCLK;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// handshakes are judged at the falling edge, where registered outputs have settled
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic       aw_go;
		logic       w_go;
		logic       b_go;
		logic [1:0] resp;
		S_AWADDR <= a;
		S_WDATA <= d;
		S_AWVALID <= 1'b1;
		S_WVALID <= 1'b1;
		do begin
			@(negedge MCLK);
			aw_go = S_AWVALID && (S_AWREADY === 1'b1);
			w_go  = S_WVALID && (S_WREADY === 1'b1);
			b_go  = (S_BVALID === 1'b1);
			resp  = S_BRESP;
			@(posedge MCLK);
			if (aw_go) S_AWVALID <= 1'b0;
			if (w_go) S_WVALID <= 1'b0;
		end while (!b_go);
		chk({30'h0, resp}, {30'h0, er});
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp, input logic [1:0] er);
		logic        ar_go;
		logic        r_go;
		logic [31:0] data;
		logic [1:0]  resp;
		S_ARADDR <= a;
		S_ARVALID <= 1'b1;
		do begin
			@(negedge MCLK);
			ar_go = S_ARVALID && (S_ARREADY === 1'b1);
			r_go  = (S_RVALID === 1'b1);
			data  = S_RDATA;
			resp  = S_RRESP;
			@(posedge MCLK);
			if (ar_go) S_ARVALID <= 1'b0;
		end while (!r_go);
		chk(data & m, exp);
		chk({30'h0, resp}, {30'h0, er});
	endtask
	task automatic arm(input logic [5:0] c, input logic [15:0] v);
		run <= 1'b0;
		clr <= 1'b1;
		@(posedge MCLK);
		clr <= 1'b0;
		wr(OFF_VALUE, {16'h0, v}, RESP_OKAY);
		wr(OFF_CONTROL, {26'h0, c}, RESP_OKAY);
		run <= 1'b1;
	endtask
	task automatic t_regs;
		rd(OFF_CONTROL, 32'h3f, 32'h20, RESP_OKAY);
		rd(OFF_VALUE, 32'hffff, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h3, 32'h0, RESP_OKAY);
		rd(4'hc, 32'hffffffff, 32'h0, RESP_SLVERR);
		wr(4'hc, 32'h1, RESP_SLVERR);
		chk({31'h0, COMPARE_PIN_OE}, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_pins;
		logic [3:0] md[4] = '{4'h9, 4'h8, 4'h2, 4'ha};
		logic       ep[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 4; i++) begin
			arm({2'b00, md[i]}, 16'h0105);
			repeat (270) @(posedge MCLK);
			chk({31'h0, COMPARE_PIN_OE}, 32'h1);
			chk({31'h0, COMPARE_PIN_O}, {31'h0, ep[i]});
			rd(OFF_STATUS, 32'h1, 32'h1, RESP_OKAY);
			wr(OFF_STATUS, 32'h1, RESP_OKAY);
			rd(OFF_STATUS, 32'h1, 32'h0, RESP_OKAY);
		end
		// flag-only mode: the pin keeps following the port latch
		PORT_LATCH <= 1'b0;
		repeat (2) @(posedge MCLK);
		chk({31'h0, COMPARE_PIN_O}, 32'h0);
		PORT_LATCH <= 1'b1;
		arm(6'h08, 16'h0105);
		repeat (270) @(posedge MCLK);
		rd(OFF_STATUS, 32'h2, 32'h2, RESP_OKAY);
		wr(OFF_CONTROL, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h2, 32'h0, RESP_OKAY);
		// equality held with a stopped timer gives a single match
		run <= 1'b0;
		clr <= 1'b1;
		@(posedge MCLK);
		clr <= 1'b0;
		wr(OFF_VALUE, 32'h0, RESP_OKAY);
		wr(OFF_STATUS, 32'h1, RESP_OKAY);
		wr(OFF_CONTROL, 32'h0a, RESP_OKAY);
		repeat (4) @(posedge MCLK);
		rd(OFF_STATUS, 32'h1, 32'h1, RESP_OKAY);
		wr(OFF_STATUS, 32'h1, RESP_OKAY);
		repeat (8) @(posedge MCLK);
		rd(OFF_STATUS, 32'h1, 32'h0, RESP_OKAY);
		$display("test pins done");
	endtask
	task automatic t_special;
		CONV_ENABLED <= 1'b0;
		arm(6'h1b, 16'h0010);
		c0 = conv_cnt;
		repeat (100) @(posedge MCLK);
		chk({24'h0, conv_cnt}, {24'h0, c0});
		chk({31'h0, TIMER_B_COUNT < 16'h0014}, 32'h1);
		CONV_ENABLED <= 1'b1;
		arm(6'h0b, 16'h0010);
		repeat (100) @(posedge MCLK);
		chk({31'h0, TIMER_A_COUNT < TIMER_B_COUNT}, 32'h1);
		chk({31'h0, conv_cnt != c0}, 32'h1);
		$display("test special done");
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		{RST_N, S_AWVALID, S_WVALID, S_ARVALID, CONV_ENABLED, run, clr} = '0;
		// responses are always accepted
		{S_BREADY, S_RREADY} = 2'b11;
		{S_AWADDR, S_ARADDR, S_WDATA} = '0;
		S_WSTRB = 4'hf;
		PORT_LATCH = 1'b1;
		repeat (2) @(posedge MCLK);
		RST_N <= 1'b1;
		@(posedge MCLK);
		t_regs();
		t_pins();
		t_special();
		tally_and_finish();
	end
endmodule
